// file: src/hcfr_regs.sv
`timescale 1ns/100ps
`default_nettype none
module hcfr_regs
   import hcfr_pkg::*;
#(
   parameter int PORTS = 2
)(
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        SYS_RST,
   input  wire logic        SOFT_RST,
   input  wire logic        BUS_RESET,
   // Memory register access
   input  wire logic        MEM_SEL,
   input  wire logic        MEM_WR,
   input  wire logic [11:0] MEM_ADDR,
   input  wire logic [31:0] MEM_WDATA,
   output logic      [31:0] MEM_RDATA,
   output logic             MEM_ACK,
   // Legacy I/O cycles
   input  wire logic        IO_SEL,
   input  wire logic        IO_WR,
   input  wire logic [15:0] IO_ADDR,
   input  wire logic [7:0]  IO_WDATA,
   input  wire logic        GATE_A20_SEQ,
   output logic      [7:0]  IO_RDATA,
   output logic             IO_CLAIM,
   // Controller side
   input  wire logic        FRAME_ADVANCE,
   input  wire logic [13:0] FRAME_TIME_LEFT,
   input  wire logic        ASYNC_BUSY,
   input  wire logic        ASYNC_REQ,
   input  wire logic        HUB_OCI_IN,
   input  wire logic        HUB_OCI_EDGE,
   input  wire logic [PORTS-1:0] PORT_UPD,
   input  wire logic [31:0] PORT_UPD_DATA [PORTS],
   output logic             PERIODIC_PRIORITY,
   output logic             START_ASYNC,
   output logic             LS_COMMIT_OK,
   output logic             EMU_ENABLED
);

   ////////////////////////////////////////////////////////////////////////////
   // Register state.
   logic [15:0] frame_count;
   logic [13:0] periodic_threshold;
   logic [10:0] low_speed_commit_limit;
   logic [31:0] hub_descriptor_first;
   logic [31:0] hub_descriptor_second;
   logic [31:0] hub_status_reg;
   logic [31:0] port_status_reg [PORTS];
   logic [EMU_CTRL_W-1:0] emulation_control_reg;
   logic [7:0]  emulation_in_reg;
   logic [7:0]  emulation_out_reg;
   logic [7:0]  emulation_status_reg;
   hcfr_sched_t sched;
   logic        legacy_decode_on;
   logic        mem_wr;
   logic        io_hit;
   logic        io_data;
   logic        io_cmd;
   logic [PORTS-1:0] port_wr;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a[11:2] == off[11:2]);
   endfunction : hit

   assign legacy_decode_on = emulation_control_reg[EMU_ENABLE];
   assign mem_wr  = MEM_SEL && MEM_WR;
   assign io_data = IO_ADDR == IO_DATA_PORT;
   assign io_cmd  = IO_ADDR == IO_CMD_PORT;
   assign io_hit  = IO_SEL && legacy_decode_on && (io_data || io_cmd);

   ////////////////////////////////////////////////////////////////////////////
   // Frame counter and thresholds.
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         frame_count <= RST_FRAME_NUMBER;
      end else if (FRAME_ADVANCE) begin
         frame_count <= frame_count + 16'h0001;
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         periodic_threshold <= RST_PERIODIC;
      end else if (mem_wr && hit(MEM_ADDR, OFF_PERIODIC_START)) begin
         periodic_threshold <= MEM_WDATA[13:0];
      end
   end

   // The limit is held at its reset value; writes are accepted but discarded
   // because neither side may change it.
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         low_speed_commit_limit <= RST_LOW_SPEED[10:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Scheduling priority.
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         sched <= HCFR_IDLE;
      end else begin
         unique case (sched)
            HCFR_IDLE: begin
               if (FRAME_TIME_LEFT <= periodic_threshold) begin
                  sched <= HCFR_PERIODIC;
               end else if (ASYNC_REQ) begin
                  sched <= HCFR_ASYNC;
               end
            end
            HCFR_ASYNC: begin
               if (!ASYNC_BUSY && FRAME_TIME_LEFT <= periodic_threshold) begin
                  sched <= HCFR_PERIODIC;
               end else if (!ASYNC_BUSY && !ASYNC_REQ) begin
                  sched <= HCFR_IDLE;
               end
            end
            HCFR_PERIODIC: begin
               if (FRAME_ADVANCE) begin
                  sched <= HCFR_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         PERIODIC_PRIORITY <= 1'b0;
         START_ASYNC       <= 1'b0;
         LS_COMMIT_OK      <= 1'b0;
         EMU_ENABLED       <= 1'b0;
      end else begin
         PERIODIC_PRIORITY <= sched == HCFR_PERIODIC;
         START_ASYNC       <= sched == HCFR_ASYNC;
         LS_COMMIT_OK      <= {3'b000, FRAME_TIME_LEFT[10:0]} > 14'(low_speed_commit_limit)
                              || FRAME_TIME_LEFT[13:11] != 3'b000;
         EMU_ENABLED       <= legacy_decode_on;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Root hub registers; SOFT_RST deliberately does not touch them.
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         hub_descriptor_first  <= RST_HUB_DESC_A;
         hub_descriptor_second <= RST_HUB_DESC_B;
      end else if (mem_wr && hit(MEM_ADDR, OFF_HUB_DESC_A)) begin
         hub_descriptor_first <= (hub_descriptor_first & ~MASK_HUB_DESC_A)
                                 | (MEM_WDATA & MASK_HUB_DESC_A);
      end else if (mem_wr && hit(MEM_ADDR, OFF_HUB_DESC_B)) begin
         hub_descriptor_second <= MEM_WDATA & MASK_HUB_DESC_B;
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         hub_status_reg <= 32'h0000_0000;
      end else if (BUS_RESET) begin
         hub_status_reg <= 32'h0000_0000;
      end else begin
         hub_status_reg[HUB_OCI] <= HUB_OCI_IN;
         if (mem_wr && hit(MEM_ADDR, OFF_HUB_STATUS)) begin
            hub_status_reg[HUB_LPS]  <= MEM_WDATA[HUB_LPS];
            hub_status_reg[HUB_REMOTE_WAKE_ENABLE] <= MEM_WDATA[HUB_REMOTE_WAKE_ENABLE] && !MEM_WDATA[HUB_REMOTE_WAKE_CLEAR];
            hub_status_reg[HUB_LOCAL_POWER_CHANGE] <= MEM_WDATA[HUB_LOCAL_POWER_CHANGE];
         end
         // Change bit in the upper half; a new event beats a clear.
         if (HUB_OCI_EDGE) begin
            hub_status_reg[HUB_OVERCURRENT_CHANGE] <= 1'b1;
         end else if (mem_wr && hit(MEM_ADDR, OFF_HUB_STATUS) && MEM_WDATA[HUB_OVERCURRENT_CHANGE]) begin
            hub_status_reg[HUB_OVERCURRENT_CHANGE] <= 1'b0;
         end
      end
   end

   genvar p;
   generate
      for (p = 0; p < PORTS; p++) begin : g_pw
         assign port_wr[p] = mem_wr && hit(MEM_ADDR, OFF_PORT_STATUS1 + 12'(4 * p));
      end
   endgenerate

   hcfr_port_bank #(.PORTS(PORTS)) u_ports (
      .clk             (CLK),
      .rst             (SYS_RST),
      .bus_reset       (BUS_RESET),
      .wr_en           (port_wr),
      .wr_data         (MEM_WDATA),
      .hw_en           (PORT_UPD),
      .hw_data         (PORT_UPD_DATA),
      .port_status_reg (port_status_reg)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Legacy emulation registers.
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         emulation_control_reg <= '0;
      end else if (mem_wr && hit(MEM_ADDR, OFF_EMU_CONTROL)) begin
         emulation_control_reg <= MEM_WDATA[EMU_CTRL_W-1:0] & 3'b101;
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         emulation_in_reg <= 8'h00;
      end else if (io_hit && IO_WR) begin
         emulation_in_reg <= IO_WDATA;
      end else if (mem_wr && hit(MEM_ADDR, OFF_EMU_INPUT)) begin
         emulation_in_reg <= MEM_WDATA[7:0];
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         emulation_out_reg <= 8'h00;
      end else if (mem_wr && hit(MEM_ADDR, OFF_EMU_OUTPUT)) begin
         emulation_out_reg <= MEM_WDATA[7:0];
      end
   end

   // I/O side effects win over a simultaneous memory write to the same flags.
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         emulation_status_reg <= 8'h00;
      end else begin
         if (mem_wr && hit(MEM_ADDR, OFF_EMU_STATUS)) begin
            emulation_status_reg <= MEM_WDATA[7:0];
         end
         if (io_hit && IO_WR) begin
            if (!GATE_A20_SEQ) begin
               emulation_status_reg[EMU_IN_FULL] <= 1'b1;
            end
            emulation_status_reg[EMU_CMD_DATA] <= io_cmd;
         end
         if (io_hit && !IO_WR && io_data) begin
            emulation_status_reg[EMU_OUT_FULL] <= 1'b0;
         end
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         IO_RDATA <= 8'h00;
         IO_CLAIM <= 1'b0;
      end else begin
         IO_CLAIM <= io_hit;
         if (io_hit && !IO_WR) begin
            IO_RDATA <= io_data ? emulation_out_reg : emulation_status_reg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Memory read path.
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         MEM_RDATA <= 32'h0000_0000;
         MEM_ACK   <= 1'b0;
      end else begin
         MEM_ACK <= MEM_SEL;
         if (MEM_SEL && !MEM_WR) begin
            unique case (MEM_ADDR[11:2])
               OFF_FRAME_NUMBER[11:2]:   MEM_RDATA <= {16'h0000, frame_count};
               OFF_PERIODIC_START[11:2]: MEM_RDATA <= {18'h0_0000, periodic_threshold};
               OFF_LOW_SPEED[11:2]:      MEM_RDATA <= {21'h00_0000, low_speed_commit_limit};
               OFF_HUB_DESC_A[11:2]:     MEM_RDATA <= hub_descriptor_first;
               OFF_HUB_DESC_B[11:2]:     MEM_RDATA <= hub_descriptor_second;
               OFF_HUB_STATUS[11:2]:     MEM_RDATA <= hub_status_reg;
               OFF_PORT_STATUS1[11:2]:   MEM_RDATA <= port_status_reg[0];
               OFF_PORT_STATUS2[11:2]:   MEM_RDATA <= port_status_reg[1];
               OFF_EMU_CONTROL[11:2]:    MEM_RDATA <= {29'h0000_0000, emulation_control_reg};
               OFF_EMU_INPUT[11:2]:      MEM_RDATA <= {24'h00_0000, emulation_in_reg};
               OFF_EMU_OUTPUT[11:2]:     MEM_RDATA <= {24'h00_0000, emulation_out_reg};
               OFF_EMU_STATUS[11:2]:     MEM_RDATA <= {24'h00_0000, emulation_status_reg};
               default:                  MEM_RDATA <= 32'h0000_0000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   a_frame_step: assert property (@(posedge CLK) disable iff (SYS_RST)
      FRAME_ADVANCE |=> frame_count == $past(frame_count) + 16'h0001)
      else $error("frame counter did not step");
   a_frame_hold: assert property (@(posedge CLK) disable iff (SYS_RST)
      !FRAME_ADVANCE |=> $stable(frame_count))
      else $error("frame counter moved without advance");
   a_ls_fixed: assert property (@(posedge CLK) disable iff (SYS_RST)
      low_speed_commit_limit == 11'h700)
      else $error("low-speed limit changed");
   a_prio_wait: assert property (@(posedge CLK) disable iff (SYS_RST)
      (sched == HCFR_ASYNC && ASYNC_BUSY) |=> sched != HCFR_PERIODIC)
      else $error("periodic took over mid transaction");
   a_prio_take: assert property (@(posedge CLK) disable iff (SYS_RST)
      (sched == HCFR_IDLE && FRAME_TIME_LEFT <= periodic_threshold) |=> ##1 PERIODIC_PRIORITY)
      else $error("periodic priority late");
   a_bus_reset: assert property (@(posedge CLK) disable iff (SYS_RST)
      (BUS_RESET && !(mem_wr && hit(MEM_ADDR, OFF_HUB_DESC_A)))
      |=> hub_status_reg == 32'h0 && port_status_reg[0] == 32'h0
          && port_status_reg[1] == 32'h0 && $stable(hub_descriptor_first))
      else $error("bus reset effect wrong");
   a_soft_keep: assert property (@(posedge CLK) disable iff (SYS_RST)
      (SOFT_RST && !BUS_RESET && !mem_wr && !PORT_UPD[0]) |=> $stable(port_status_reg[0]))
      else $error("software reset changed a port register");
   a_rd_data_port: assert property (@(posedge CLK) disable iff (SYS_RST)
      (io_hit && !IO_WR && io_data) |=> !emulation_status_reg[EMU_OUT_FULL]
                                        && IO_RDATA == $past(emulation_out_reg))
      else $error("port 60h read wrong");
   a_wr_cmd_port: assert property (@(posedge CLK) disable iff (SYS_RST)
      (io_hit && IO_WR && io_cmd && !GATE_A20_SEQ) |=> emulation_status_reg[EMU_IN_FULL]
         && emulation_status_reg[EMU_CMD_DATA] && emulation_in_reg == $past(IO_WDATA))
      else $error("port 64h write wrong");
   a_wr_data_port: assert property (@(posedge CLK) disable iff (SYS_RST)
      (io_hit && IO_WR && io_data && !GATE_A20_SEQ) |=> emulation_status_reg[EMU_IN_FULL]
         && !emulation_status_reg[EMU_CMD_DATA])
      else $error("port 60h write wrong");
   a_decode_off: assert property (@(posedge CLK) disable iff (SYS_RST)
      (IO_SEL && !legacy_decode_on && !(mem_wr && hit(MEM_ADDR, OFF_EMU_STATUS)))
      |=> !IO_CLAIM && $stable(emulation_status_reg))
      else $error("port claimed while disabled");

   c_periodic: cover property (@(posedge CLK) disable iff (SYS_RST)
      sched == HCFR_ASYNC ##1 sched == HCFR_PERIODIC);
   c_io_read: cover property (@(posedge CLK) disable iff (SYS_RST) io_hit && !IO_WR && io_data);
   c_io_write: cover property (@(posedge CLK) disable iff (SYS_RST) io_hit && IO_WR && io_cmd);
   c_bus_reset: cover property (@(posedge CLK) disable iff (SYS_RST) BUS_RESET);

endmodule : hcfr_regs
`default_nettype wire

// file: src/hcfr_pkg.sv
package hcfr_pkg;

   // Operational register byte offsets.
   localparam logic [11:0] OFF_FRAME_NUMBER   = 12'h03C;
   localparam logic [11:0] OFF_PERIODIC_START = 12'h040;
   localparam logic [11:0] OFF_LOW_SPEED      = 12'h044;
   localparam logic [11:0] OFF_HUB_DESC_A     = 12'h048;
   localparam logic [11:0] OFF_HUB_DESC_B     = 12'h04C;
   localparam logic [11:0] OFF_HUB_STATUS     = 12'h050;
   localparam logic [11:0] OFF_PORT_STATUS1   = 12'h054;
   localparam logic [11:0] OFF_PORT_STATUS2   = 12'h058;
   localparam logic [11:0] OFF_EMU_CONTROL    = 12'h100;
   localparam logic [11:0] OFF_EMU_INPUT      = 12'h104;
   localparam logic [11:0] OFF_EMU_OUTPUT     = 12'h108;
   localparam logic [11:0] OFF_EMU_STATUS     = 12'h10C;

   // Legacy I/O ports.
   localparam logic [15:0] IO_DATA_PORT = 16'h0060;
   localparam logic [15:0] IO_CMD_PORT  = 16'h0064;

   // Reset values and write masks.
   localparam logic [15:0] RST_FRAME_NUMBER = 16'h0000;
   localparam logic [13:0] RST_PERIODIC     = 14'h0000;
   localparam logic [11:0] RST_LOW_SPEED    = 12'h0700;
   localparam logic [31:0] RST_HUB_DESC_A   = 32'hFF00_0A02;
   localparam logic [31:0] RST_HUB_DESC_B   = 32'h0006_0000;
   localparam logic [31:0] MASK_HUB_DESC_A  = 32'hFF00_1B00;
   localparam logic [31:0] MASK_HUB_DESC_B  = 32'h0003_FFFF;
   localparam logic [31:0] MASK_PORT_STATUS = 32'h001F_031F;

   // Field positions.
   localparam int HUB_LPS   = 0;
   localparam int HUB_OCI   = 1;
   localparam int HUB_REMOTE_WAKE_ENABLE  = 15;
   localparam int HUB_LOCAL_POWER_CHANGE  = 16;
   localparam int HUB_OVERCURRENT_CHANGE  = 17;
   localparam int HUB_REMOTE_WAKE_CLEAR  = 31;
   localparam int EMU_OUT_FULL = 0;
   localparam int EMU_IN_FULL  = 1;
   localparam int EMU_CMD_DATA = 3;
   localparam int EMU_ENABLE   = 0;
   localparam int EMU_CTRL_W   = 3;

   // Low-speed packet limit in bytes.
   localparam int LS_MAX_BYTES = 8;

   typedef enum logic [2:0] {
      HCFR_IDLE     = 3'b001,
      HCFR_ASYNC    = 3'b010,
      HCFR_PERIODIC = 3'b100
   } hcfr_sched_t;

endpackage : hcfr_pkg

// file: src/hcfr_port_bank.sv
`timescale 1ns/100ps
`default_nettype none
// Per-port status registers; cleared by hardware reset or bus reset.
module hcfr_port_bank
   import hcfr_pkg::*;
#(
   parameter int PORTS = 2
)(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              bus_reset,
   // Write access
   input  wire logic [PORTS-1:0]  wr_en,
   input  wire logic [31:0]       wr_data,
   // Controller updates
   input  wire logic [PORTS-1:0]  hw_en,
   input  wire logic [31:0]       hw_data [PORTS],
   // Register contents
   output logic      [31:0]       port_status_reg [PORTS]
);

   genvar g;
   generate
      for (g = 0; g < PORTS; g++) begin : g_port
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               port_status_reg[g] <= 32'h0000_0000;
            end else if (bus_reset) begin
               port_status_reg[g] <= 32'h0000_0000;
            end else if (hw_en[g]) begin
               port_status_reg[g] <= hw_data[g] & MASK_PORT_STATUS;
            end else if (wr_en[g]) begin
               port_status_reg[g] <= wr_data & MASK_PORT_STATUS;
            end
         end
      end
   endgenerate

endmodule : hcfr_port_bank
`default_nettype wire

// file: tb/hcfr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// Host bus master: one dword access per call, answer taken at the edge that shows the ack.
module hcfr_host_model (
   // Clock
   input  wire logic        clk,
   // Memory access
   output var  logic        mem_sel,
   output var  logic        mem_wr,
   output var  logic [11:0] mem_addr,
   output var  logic [31:0] mem_wdata,
   input  wire logic [31:0] mem_rdata,
   input  wire logic        mem_ack
);
   initial begin
      mem_sel   = 1'b0;
      mem_wr    = 1'b0;
      mem_addr  = 12'h000;
      mem_wdata = 32'h0000_0000;
   end
   // Only whole dwords are sent, so the low address bits are zero while a request stands.
   task automatic access(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                         output logic [31:0] rd, output logic ack);
      int n;
      n = 0;
      @(posedge clk);
      mem_sel   <= 1'b1;
      mem_wr    <= wr;
      mem_addr  <= {addr[11:2], 2'b00};
      mem_wdata <= wd;
      // The request stands until the acknowledge is seen; the block takes it once more
      // meanwhile, which is harmless because every access made here is idempotent.
      do begin
         @(posedge clk);
         n++;
      end while (mem_ack !== 1'b1 && n < 4);
      rd  = mem_rdata;
      ack = mem_ack;
      mem_sel   <= 1'b0;
      // Released address and data lines show the inverse, so stale values can never look valid.
      mem_addr  <= ~addr;
      mem_wdata <= ~wd;
   endtask : access
endmodule : hcfr_host_model
`default_nettype wire

// file: tb/test_hc_frame_roothub_legacy_regs.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module test_hc_frame_roothub_legacy_regs;
   import hcfr_pkg::*;
   logic clk = 1'b0, sys_rst = 1'b1, soft_rst = 1'b0, bus_reset = 1'b0;
   logic mem_sel, mem_wr, mem_ack, io_claim, prio, start_async, ls_ok, emu_en;
   logic [11:0] mem_addr;
   logic [31:0] mem_wdata, mem_rdata, r, m_a, m_b, m_p1, m_p2;
   logic io_sel = 1'b0, io_wr = 1'b0, gate_a20 = 1'b0, frame_adv = 1'b0;
   logic async_busy = 1'b0, async_req = 1'b0, oci_in = 1'b0, oci_edge = 1'b0;
   logic [15:0] io_addr = 16'h0000;
   logic [7:0]  io_wdata = 8'h00, io_rdata, d;
   logic [13:0] time_left = 14'h3FFF;
   logic [1:0]  port_upd = 2'b00;
   logic [31:0] upd_data [2] = '{32'h0000_0000, 32'h0000_0000};
   logic [15:0] m_fn = 16'h0000;
   int n_mismatch = 0;
   int tests_run = 0;
   logic [11:0] ra [12] = '{OFF_FRAME_NUMBER, OFF_PERIODIC_START, OFF_LOW_SPEED,
      OFF_HUB_DESC_A, OFF_HUB_DESC_B, OFF_HUB_STATUS, OFF_PORT_STATUS1, OFF_PORT_STATUS2,
      OFF_EMU_CONTROL, OFF_EMU_INPUT, OFF_EMU_OUTPUT, OFF_EMU_STATUS};
   logic [31:0] re [12] = '{2: 32'(RST_LOW_SPEED), 3: RST_HUB_DESC_A, 4: RST_HUB_DESC_B,
      default: 32'h0000_0000};

   always #12.5 clk = ~clk;

   hcfr_regs #(.PORTS(2)) hcfr_regs_i (
      .CLK(clk), .SYS_RST(sys_rst), .SOFT_RST(soft_rst), .BUS_RESET(bus_reset),
      .MEM_SEL(mem_sel), .MEM_WR(mem_wr), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
      .MEM_RDATA(mem_rdata), .MEM_ACK(mem_ack), .IO_SEL(io_sel), .IO_WR(io_wr),
      .IO_ADDR(io_addr), .IO_WDATA(io_wdata), .GATE_A20_SEQ(gate_a20), .IO_RDATA(io_rdata),
      .IO_CLAIM(io_claim), .FRAME_ADVANCE(frame_adv), .FRAME_TIME_LEFT(time_left),
      .ASYNC_BUSY(async_busy), .ASYNC_REQ(async_req), .HUB_OCI_IN(oci_in),
      .HUB_OCI_EDGE(oci_edge), .PORT_UPD(port_upd), .PORT_UPD_DATA(upd_data),
      .PERIODIC_PRIORITY(prio), .START_ASYNC(start_async), .LS_COMMIT_OK(ls_ok),
      .EMU_ENABLED(emu_en));

   hcfr_host_model hcfr_host_model_i (
      .clk(clk), .mem_sel(mem_sel), .mem_wr(mem_wr), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic mwr(input logic [11:0] a, input logic [31:0] w);
      logic [31:0] rd;
      logic ack;
      hcfr_host_model_i.access(1'b1, a, w, rd, ack);
   endtask : mwr
   task automatic mchk(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] rd;
      logic ack;
      hcfr_host_model_i.access(1'b0, a, 32'h0000_0000, rd, ack);
      `CHK(ack, 1'b1)
      `CHK(rd, e)
   endtask : mchk
   task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] w,
                     input logic g, input logic [7:0] e, input logic c);
      @(posedge clk);
      io_sel <= 1'b1;
      io_wr <= wr;
      io_addr <= a;
      io_wdata <= w;
      gate_a20 <= g;
      // The cycle is held until the edge at which its claim and read data are sampled.
      repeat (2) @(posedge clk);
      `CHK(io_claim, c)
      if (!wr && c) `CHK(io_rdata, e)
      io_sel <= 1'b0;
      io_wdata <= ~w;
      gate_a20 <= 1'b0;
   endtask : io
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic adv();
      @(posedge clk) frame_adv <= 1'b1;
      @(posedge clk) frame_adv <= 1'b0;
      m_fn++;
   endtask : adv
   task automatic summarize();
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      summarize();
   end

   initial begin
      void'($urandom(32'h781f));
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 12; i++) mchk(ra[i], re[i]);
      r = $urandom;
      mwr(OFF_PERIODIC_START, r);
      mchk(OFF_PERIODIC_START, r & 32'h0000_3FFF);
      mwr(OFF_PERIODIC_START, 32'h0000_3E67);
      mwr(OFF_LOW_SPEED, r);
      mchk(OFF_LOW_SPEED, 32'(RST_LOW_SPEED));
      // Control work is mid-transaction when the threshold is crossed.
      @(posedge clk) async_req <= 1'b1;
      async_busy <= 1'b1;
      tick(4);
      `CHK(start_async, 1'b1)
      @(posedge clk) time_left <= 14'h3000;
      tick(6);
      `CHK(prio, 1'b0)
      @(posedge clk) async_busy <= 1'b0;
      for (int i = 0; i < 8 && prio !== 1'b1; i++) tick(1);
      `CHK(prio, 1'b1)
      `CHK(start_async, 1'b0)
      @(posedge clk) async_req <= 1'b0;
      time_left <= 14'h0701;
      adv();
      tick(3);
      `CHK(ls_ok, 1'b1)
      @(posedge clk) time_left <= 14'h0700;
      tick(3);
      `CHK(ls_ok, 1'b0)
      @(posedge clk) time_left <= 14'h3FFF;
      adv();
      tick(3);
      `CHK(prio, 1'b0)
      mwr(OFF_FRAME_NUMBER, $urandom);
      repeat ($urandom_range(3, 9)) adv();
      mchk(OFF_FRAME_NUMBER, {16'h0000, m_fn});
      // Root hub descriptors, ports and hub status.
      r = $urandom;
      m_a = (r & MASK_HUB_DESC_A) | (RST_HUB_DESC_A & ~MASK_HUB_DESC_A);
      m_b = r & MASK_HUB_DESC_B;
      mwr(OFF_HUB_DESC_A, r);
      mwr(OFF_HUB_DESC_B, r);
      r = $urandom;
      m_p1 = r & MASK_PORT_STATUS;
      mwr(OFF_PORT_STATUS1, r);
      mwr(OFF_PORT_STATUS2, ~r);
      r = $urandom;
      m_p2 = r & MASK_PORT_STATUS;
      @(posedge clk) port_upd <= 2'b10;
      upd_data[1] <= r;
      oci_in <= 1'b1;
      @(posedge clk) port_upd <= 2'b00;
      oci_edge <= 1'b1;
      @(posedge clk) oci_edge <= 1'b0;
      mchk(OFF_PORT_STATUS1, m_p1);
      mchk(OFF_PORT_STATUS2, m_p2);
      mwr(OFF_HUB_STATUS, 32'h0000_0001);
      mchk(OFF_HUB_STATUS, 32'h0002_0003);
      mwr(OFF_HUB_STATUS, 32'h0002_0001);
      mchk(OFF_HUB_STATUS, 32'h0000_0003);
      @(posedge clk) soft_rst <= 1'b1;
      oci_in <= 1'b0;
      @(posedge clk) soft_rst <= 1'b0;
      mchk(OFF_PORT_STATUS1, m_p1);
      @(posedge clk) bus_reset <= 1'b1;
      @(posedge clk) bus_reset <= 1'b0;
      mchk(OFF_HUB_STATUS, 32'h0000_0000);
      mchk(OFF_PORT_STATUS1, 32'h0000_0000);
      mchk(OFF_PORT_STATUS2, 32'h0000_0000);
      mchk(OFF_HUB_DESC_A, m_a);
      mchk(OFF_HUB_DESC_B, m_b);
      mchk(OFF_PERIODIC_START, 32'h0000_3E67);
      mchk(12'h110, 32'h0000_0000);
      // Legacy emulation.
      io(1'b1, IO_DATA_PORT, 8'h5A, 1'b0, 8'h00, 1'b0);
      mchk(OFF_EMU_INPUT, 32'h0000_0000);
      mwr(OFF_EMU_CONTROL, 32'h0000_0001);
      tick(1);
      `CHK(emu_en, 1'b1)
      mchk(OFF_EMU_CONTROL, 32'h0000_0001);
      mwr(OFF_EMU_OUTPUT, 32'h0000_00A5);
      mwr(OFF_EMU_STATUS, 32'h0000_0001);
      io(1'b0, IO_DATA_PORT, 8'h00, 1'b0, 8'hA5, 1'b1);
      mchk(OFF_EMU_STATUS, 32'h0000_0000);
      d = 8'($urandom);
      io(1'b1, IO_DATA_PORT, d, 1'b0, 8'h00, 1'b1);
      mchk(OFF_EMU_INPUT, {24'h00_0000, d});
      mchk(OFF_EMU_STATUS, 32'h0000_0002);
      d = 8'($urandom);
      io(1'b1, IO_CMD_PORT, d, 1'b0, 8'h00, 1'b1);
      mchk(OFF_EMU_INPUT, {24'h00_0000, d});
      io(1'b0, IO_CMD_PORT, 8'h00, 1'b0, 8'h0A, 1'b1);
      mchk(OFF_EMU_STATUS, 32'h0000_000A);
      mwr(OFF_EMU_STATUS, 32'h0000_0000);
      io(1'b1, IO_DATA_PORT, 8'h3C, 1'b1, 8'h00, 1'b1);
      mchk(OFF_EMU_STATUS, 32'h0000_0000);
      io(1'b0, 16'h0061, 8'h00, 1'b0, 8'h00, 1'b0);
      // A hardware reset in mid-run restores the hub and emulation registers.
      @(posedge clk) sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      mchk(OFF_HUB_DESC_A, RST_HUB_DESC_A);
      mchk(OFF_EMU_CONTROL, 32'h0000_0000);
      tick(1);
      `CHK(emu_en, 1'b0)
      summarize();
   end
endmodule : test_hc_frame_roothub_legacy_regs
`default_nettype wire
